/* hw/urf_uart.sv */
/*
  serial port core: flags, receive frame format, baud generator with
  integer and fractional divisor, transmitter with xon/xoff, receiver.
  assumes inputs synchronous to clk and a master that never waits.
*/
module urf_uart #(
  parameter int Depth = 16
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  input wire logic rxLine,
  input wire logic clearToSend,
  output logic txLine,
  output logic irq
);
  initial
  begin
    if (Depth < 2 || Depth > 256 || (Depth & (Depth - 1)) != 0)
      $error("Depth must be a power of two from 2 to 256");
  end
  localparam int AW = $clog2(Depth);
  typedef enum {SerIdle, SerStart, SerData, SerParity, SerStop} urf_ser_e;

  function automatic logic [3:0] wordBits(input logic [1:0] wl);
    wordBits = 4'h5 + {2'h0, wl};
  endfunction : wordBits

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic rstA_q, rstB_q, rstN;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst) {rstB_q, rstA_q} <= 2'h0;
    else {rstB_q, rstA_q} <= {rstA_q, 1'h1};
  end
  assign rstN = rstB_q;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0] rlc_q, xon_q, xoff_q;
  logic [2:0] ctl_q;
  logic [3:0] trig_q;
  logic [15:0] baud_div_integer_q, divIntAct_q;
  logic [5:0] baud_div_fraction_q, divFracAct_q;
  localparam int IRQ_W_L = urf_pkg::IRQ_W - 1;
  logic [IRQ_W_L:0] irqSt_q, irqMask_q, irqEv;
  logic wrAt;
  wire logic txBusy, rxBusy;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      rlc_q <= urf_pkg::RLC_RESET;
      ctl_q <= 3'h0;
      baud_div_integer_q <= urf_pkg::DIV_INT_RESET;
      baud_div_fraction_q <= urf_pkg::DIV_FRAC_RESET;
      trig_q <= urf_pkg::FLOW_TRIG_RESET;
      xon_q <= urf_pkg::XON_RESET;
      xoff_q <= urf_pkg::XOFF_RESET;
      irqMask_q <= '0;
    end
    else if (regWr)
    begin
      if (hit(regAddr, urf_pkg::RX_LINE_CONTROL_OFS)) rlc_q <= regWdata[7:0] & urf_pkg::RLC_MASK;
      if (hit(regAddr, urf_pkg::CONTROL_OFS)) ctl_q <= regWdata[2:0];
      if (hit(regAddr, urf_pkg::BAUD_INTEGER_OFS)) baud_div_integer_q <= regWdata[15:0];
      if (hit(regAddr, urf_pkg::BAUD_FRACTION_OFS)) baud_div_fraction_q <= regWdata[5:0];
      if (hit(regAddr, urf_pkg::FLOW_CONTROL_OFS))
      begin
        trig_q <= regWdata[3:0];
        xon_q <= regWdata[15:8];
        xoff_q <= regWdata[23:16];
      end
      if (hit(regAddr, urf_pkg::IRQ_MASK_OFS)) irqMask_q <= regWdata[IRQ_W_L:0];
    end
  end

  // divisor goes live only while neither side is inside a character
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      divIntAct_q <= urf_pkg::DIV_INT_RESET;
      divFracAct_q <= urf_pkg::DIV_FRAC_RESET;
    end
    else if (!txBusy && !rxBusy)
    begin
      divIntAct_q <= baud_div_integer_q;
      divFracAct_q <= baud_div_fraction_q;
    end
  end

  // ---------------------------------------------------------------
  // baud generator: one tick per oversample period
  // ---------------------------------------------------------------
  // fraction handled by a 64ths accumulator adding one reference cycle
  logic [15:0] bCnt_q;
  logic [6:0] fAcc_q;
  logic tick;
  logic divLoad;
  logic [6:0] fSum;
  assign fSum = fAcc_q + {1'h0, divFracAct_q};
  assign tick = (divIntAct_q != 16'h0000) && (bCnt_q == 16'h0000);
  // restart the count with a new divisor, else a long old count delays it
  assign divLoad = !txBusy && !rxBusy
    && (baud_div_integer_q != divIntAct_q || baud_div_fraction_q != divFracAct_q);
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      bCnt_q <= 16'h0000;
      fAcc_q <= 7'h00;
    end
    else if (divLoad)
    begin
      bCnt_q <= 16'h0000;
      fAcc_q <= 7'h00;
    end
    else if (tick)
    begin
      fAcc_q <= {1'h0, fSum[5:0]};
      bCnt_q <= fSum[6] ? divIntAct_q : divIntAct_q - 16'h0001;
    end
    else if (bCnt_q != 16'h0000) bCnt_q <= bCnt_q - 16'h0001;
    else bCnt_q <= divIntAct_q;
  end
  logic [3:0] ovsLast;
  assign ovsLast = ctl_q[urf_pkg::CTL_OVERSAMPLE] ? 4'(urf_pkg::OVS_FAST - 1)
                                                  : 4'(urf_pkg::OVS_SLOW - 1);

  // ---------------------------------------------------------------
  // queues
  // ---------------------------------------------------------------
  logic [7:0] txMem [Depth];
  logic [7:0] rxMem [Depth];
  logic [AW:0] txCnt_q, rxCnt_q;
  logic [AW-1:0] txRp_q, txWp_q, rxRp_q, rxWp_q;
  logic txQon, rxQon, txFull, rxFull, txPush, txPop, rxPush, rxPop;
  assign txQon = ctl_q[urf_pkg::CTL_TX_QUEUE_ON];
  assign rxQon = rlc_q[urf_pkg::RLC_QUEUE_ON];
  assign txFull = txQon ? (txCnt_q == (AW+1)'(Depth)) : (txCnt_q != '0);
  assign rxFull = rxQon ? (rxCnt_q == (AW+1)'(Depth)) : (rxCnt_q != '0);
  assign txPush = regWr && hit(regAddr, urf_pkg::TX_DATA_OFS) && !txFull;
  assign rxPop = regRd && hit(regAddr, urf_pkg::RX_DATA_OFS) && (rxCnt_q != '0);

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      txCnt_q <= '0;
      txRp_q <= '0;
      txWp_q <= '0;
    end
    else
    begin
      if (txPush) txWp_q <= txWp_q + 1'b1;
      if (txPop) txRp_q <= txRp_q + 1'b1;
      txCnt_q <= txCnt_q + (AW+1)'(txPush) - (AW+1)'(txPop);
    end
  end
  always_ff @(posedge clk)
  begin
    if (txPush) txMem[txWp_q] <= regWdata[7:0];
  end

  // ---------------------------------------------------------------
  // transmitter with xon/xoff insertion
  // ---------------------------------------------------------------
  urf_ser_e txSt_q;
  logic [3:0] txOvs_q, txBit_q;
  logic [7:0] txSh_q;
  logic txStop2_q, halted_q, sendFlow_q, flowIsXoff_q, txCtl_q;
  logic swFlow, needXoff, needXon;
  assign swFlow = ctl_q[urf_pkg::CTL_SW_FLOW];
  assign needXoff = swFlow && !halted_q && (rxCnt_q > (AW+1)'(trig_q));
  assign needXon = halted_q && (!swFlow || rxCnt_q <= (AW+1)'(trig_q));
  assign txPop = (txSt_q == SerIdle) && tick && (txCnt_q != '0) && !needXoff && !needXon;
  assign txBusy = (txSt_q != SerIdle) || (txCnt_q != '0);

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      txSt_q <= SerIdle;
      txOvs_q <= 4'h0;
      txBit_q <= 4'h0;
      txSh_q <= 8'h00;
      txLine <= 1'h1;
      txStop2_q <= 1'h0;
      halted_q <= 1'h0;
      txCtl_q <= 1'h0;
    end
    else if (tick)
    begin
      case (txSt_q)
        SerIdle:
        begin
          txOvs_q <= 4'h0;
          txStop2_q <= 1'h0;
          if (needXoff || needXon)
          begin
            txSh_q <= needXoff ? xoff_q : xon_q;
            txCtl_q <= 1'h1;
            halted_q <= needXoff;
            txLine <= 1'h0;
            txSt_q <= SerStart;
          end
          else if (txPop)
          begin
            txSh_q <= txMem[txRp_q];
            txCtl_q <= 1'h0;
            txLine <= 1'h0;
            txSt_q <= SerStart;
          end
        end
        default:
        begin
          txOvs_q <= txOvs_q + 4'h1;
          if (txOvs_q == ovsLast)
          begin
            txOvs_q <= 4'h0;
            case (txSt_q)
              SerStart:
              begin
                txLine <= txSh_q[0];
                txSh_q <= txSh_q >> 1;
                txBit_q <= 4'h1;
                txSt_q <= SerData;
              end
              SerData:
              begin
                if (txBit_q == 4'h8)
                begin
                  txLine <= 1'h1;
                  txSt_q <= SerStop;
                end
                else
                begin
                  txLine <= txSh_q[0];
                  txSh_q <= txSh_q >> 1;
                  txBit_q <= txBit_q + 4'h1;
                end
              end
              default:
              begin
                txStop2_q <= 1'h1;
                if (txStop2_q || !txCtl_q) txSt_q <= SerIdle;
              end
            endcase
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // receiver
  // ---------------------------------------------------------------
  urf_ser_e rxSt_q;
  logic [3:0] rxOvs_q, rxBit_q;
  logic [7:0] rxSh_q;
  logic rxPar_q, rxStopN_q, parErr, frmErr;
  logic [3:0] nBits;
  logic halfPt, expPar;
  assign nBits = wordBits(rlc_q[urf_pkg::RLC_WLEN_LO +: 2]);
  assign halfPt = tick && (rxOvs_q == {1'h0, ovsLast[3:1]});
  // wanted xor of data and parity, also the fixed stick bit: even 0, odd 1
  assign expPar = !rlc_q[urf_pkg::RLC_EVEN];
  assign rxBusy = rxSt_q != SerIdle;
  assign parErr = rxPar_q && rlc_q[urf_pkg::RLC_PARITY_ON];
  assign rxPush = halfPt && rxSt_q == SerStop && rxLine && !rxStopN_q && !rxFull;

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      rxSt_q <= SerIdle;
      rxOvs_q <= 4'h0;
      rxBit_q <= 4'h0;
      rxSh_q <= 8'h00;
      rxPar_q <= 1'h0;
      rxStopN_q <= 1'h0;
      irqEv <= '0;
    end
    else
    begin
      irqEv <= '0;
      if (tick)
      begin
        rxOvs_q <= (rxOvs_q == ovsLast) ? 4'h0 : rxOvs_q + 4'h1;
        if (rxSt_q == SerIdle && !rxLine)
        begin
          rxOvs_q <= 4'h0;
          rxSt_q <= SerStart;
        end
      end
      if (halfPt)
      begin
        case (rxSt_q)
          SerStart:
          begin
            rxBit_q <= 4'h0;
            rxPar_q <= 1'h0;
            rxSt_q <= rxLine ? SerIdle : SerData;
          end
          SerData:
          begin
            rxSh_q <= {rxLine, rxSh_q[7:1]};
            rxPar_q <= rxPar_q ^ rxLine;
            rxBit_q <= rxBit_q + 4'h1;
            if (rxBit_q + 4'h1 == nBits)
            begin
              rxStopN_q <= rlc_q[urf_pkg::RLC_TWO_STOP];
              rxSt_q <= rlc_q[urf_pkg::RLC_PARITY_ON] ? SerParity : SerStop;
            end
          end
          SerParity:
          begin
            if (rlc_q[urf_pkg::RLC_STICK]) rxPar_q <= rxLine ^ expPar;
            else rxPar_q <= rxPar_q ^ rxLine ^ expPar;
            rxSt_q <= SerStop;
          end
          SerStop:
          begin
            if (!rxLine)
            begin
              irqEv[urf_pkg::IRQ_FRAME_ERR] <= 1'h1;
              rxSt_q <= SerIdle;
            end
            else if (rxStopN_q) rxStopN_q <= 1'h0;
            else
            begin
              irqEv[urf_pkg::IRQ_RX_DONE] <= 1'h1;
              irqEv[urf_pkg::IRQ_PARITY_ERR] <= parErr;
              rxSt_q <= SerIdle;
            end
          end
          default: rxSt_q <= SerIdle;
        endcase
      end
    end
  end

  logic [7:0] rxWord;
  assign rxWord = rxSh_q >> (4'h8 - nBits);
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      rxCnt_q <= '0;
      rxRp_q <= '0;
      rxWp_q <= '0;
    end
    else
    begin
      if (rxPush) rxWp_q <= rxQon ? rxWp_q + 1'b1 : rxWp_q;
      if (rxPop) rxRp_q <= rxQon ? rxRp_q + 1'b1 : rxRp_q;
      rxCnt_q <= rxCnt_q + (AW+1)'(rxPush) - (AW+1)'(rxPop);
    end
  end
  always_ff @(posedge clk)
  begin
    if (rxPush) rxMem[rxWp_q] <= rxWord;
  end

  // ---------------------------------------------------------------
  // clear-to-send tracking and interrupts
  // ---------------------------------------------------------------
  logic ctsLast_q, ctsDelta_q, flagRd, ctsChg;
  assign flagRd = regRd && hit(regAddr, urf_pkg::LINE_FLAGS_OFS);
  assign ctsChg = clearToSend != ctsLast_q;
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      ctsLast_q <= 1'h0;
      ctsDelta_q <= 1'h1;
    end
    else
    begin
      ctsLast_q <= clearToSend;
      if (ctsChg) ctsDelta_q <= 1'h1;
      else if (flagRd) ctsDelta_q <= 1'h0;
    end
  end

  logic [IRQ_W_L:0] irqSet;
  assign irqSet = irqEv | (IRQ_W_L + 1)'(ctsChg) << urf_pkg::IRQ_CTS_CHANGE;
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN) irqSt_q <= '0;
    else if (regWr && hit(regAddr, urf_pkg::IRQ_STATUS_OFS))
      irqSt_q <= (irqSt_q & ~regWdata[IRQ_W_L:0]) | irqSet;
    else irqSt_q <= irqSt_q | irqSet;
  end
  assign irq = |(irqSt_q & irqMask_q);

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  logic [31:0] flags, rdMux;
  always_comb
  begin
    flags = 32'h0000_0000;
    flags[urf_pkg::FLAG_CTS] = clearToSend;
    flags[urf_pkg::FLAG_BUSY] = txBusy;
    flags[urf_pkg::FLAG_RX_EMPTY] = rxCnt_q == '0;
    flags[urf_pkg::FLAG_TX_FULL] = txFull;
    flags[urf_pkg::FLAG_RX_FULL] = rxFull;
    flags[urf_pkg::FLAG_TX_EMPTY] = txCnt_q == '0;
    flags[urf_pkg::FLAG_CTS_DELTA] = ctsDelta_q;
    flags[urf_pkg::FLAG_RSV_LO +: 3] = urf_pkg::FLAG_RSV_VALUE;
    flags[urf_pkg::FLAG_REMOTE_HALTED] = halted_q;
    rdMux = 32'h0000_0000;
    case (regAddr)
      urf_pkg::LINE_FLAGS_OFS: rdMux = flags;
      urf_pkg::RX_LINE_CONTROL_OFS: rdMux = {24'h0, rlc_q};
      urf_pkg::BAUD_INTEGER_OFS: rdMux = {16'h0, baud_div_integer_q};
      urf_pkg::BAUD_FRACTION_OFS: rdMux = {26'h0, baud_div_fraction_q};
      urf_pkg::CONTROL_OFS: rdMux = {29'h0, ctl_q};
      urf_pkg::RX_DATA_OFS: rdMux = {24'h0, rxMem[rxRp_q]};
      urf_pkg::IRQ_STATUS_OFS: rdMux = {28'h0, irqSt_q};
      urf_pkg::IRQ_MASK_OFS: rdMux = {28'h0, irqMask_q};
      urf_pkg::FLOW_CONTROL_OFS: rdMux = {8'h0, xoff_q, xon_q, 4'h0, trig_q};
      default: rdMux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN) regRdata <= 32'h0000_0000;
    else regRdata <= regRd ? rdMux : 32'h0000_0000;
  end
endmodule : urf_uart

/* hw/urf_pkg.sv */
/*
  package for the serial port flag, receive format and baud divisor block.
  assumes a single 20 MHz clock and a plain strobe register port.
*/
package urf_pkg;
  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] LINE_FLAGS_OFS = 8'h18;
  localparam logic [7:0] RX_LINE_CONTROL_OFS = 8'h1c;
  localparam logic [7:0] BAUD_INTEGER_OFS = 8'h24;
  localparam logic [7:0] BAUD_FRACTION_OFS = 8'h28;
  localparam logic [7:0] CONTROL_OFS = 8'h30;
  localparam logic [7:0] TX_DATA_OFS = 8'h00;
  localparam logic [7:0] RX_DATA_OFS = 8'h04;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'h40;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h44;
  localparam logic [7:0] FLOW_CONTROL_OFS = 8'h48;
  // ---------------------------------------------------------------
  // flag register fields
  // ---------------------------------------------------------------
  localparam int FLAG_CTS = 0;
  localparam int FLAG_BUSY = 3;
  localparam int FLAG_RX_EMPTY = 4;
  localparam int FLAG_TX_FULL = 5;
  localparam int FLAG_RX_FULL = 6;
  localparam int FLAG_TX_EMPTY = 7;
  localparam int FLAG_CTS_DELTA = 9;
  localparam int FLAG_RSV_LO = 10;
  localparam logic [2:0] FLAG_RSV_VALUE = 3'h7;
  localparam int FLAG_REMOTE_HALTED = 13;
  // ---------------------------------------------------------------
  // receive line control fields
  // ---------------------------------------------------------------
  localparam int RLC_PARITY_ON = 1;
  localparam int RLC_EVEN = 2;
  localparam int RLC_TWO_STOP = 3;
  localparam int RLC_QUEUE_ON = 4;
  localparam int RLC_WLEN_LO = 5;
  localparam int RLC_STICK = 7;
  localparam logic [7:0] RLC_RESET = 8'h00;
  localparam logic [7:0] RLC_MASK = 8'hfe;
  // ---------------------------------------------------------------
  // control fields and divisor widths
  // ---------------------------------------------------------------
  localparam int CTL_TX_QUEUE_ON = 0;
  localparam int CTL_OVERSAMPLE = 1;
  localparam int CTL_SW_FLOW = 2;
  localparam int DIV_INT_W = 16;
  localparam int DIV_FRAC_W = 6;
  localparam logic [15:0] DIV_INT_RESET = 16'h0000;
  localparam logic [5:0] DIV_FRAC_RESET = 6'h00;
  localparam logic [3:0] FLOW_TRIG_RESET = 4'h8;
  localparam logic [7:0] XON_RESET = 8'h11;
  localparam logic [7:0] XOFF_RESET = 8'h13;
  // ---------------------------------------------------------------
  // interrupt status bits and oversample ratios
  // ---------------------------------------------------------------
  localparam int IRQ_RX_DONE = 0;
  localparam int IRQ_PARITY_ERR = 1;
  localparam int IRQ_FRAME_ERR = 2;
  localparam int IRQ_CTS_CHANGE = 3;
  localparam int IRQ_W = 4;
  localparam int OVS_SLOW = 16;
  localparam int OVS_FAST = 8;
endpackage : urf_pkg

/* sim/urf_uart_sva.sv */
/*
  checker on the top ports of the serial port block.
  assumes the divisor is only rewritten while the line is idle.
*/
module urf_uart_sva (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regRdata,
  input wire logic rxLine,
  input wire logic clearToSend,
  input wire logic txLine,
  input wire logic irq
);
  // ---------------------------------------------------------------
  // shadows of software state
  // ---------------------------------------------------------------
  logic [7:0] rlc_q;
  logic [15:0] div_q;
  logic fast_q;
  logic ctsPrev_q;
  logic chg_q;
  logic [31:0] lowRun_q;
  logic flagsRd;
  logic [31:0] bitLen;
  assign flagsRd = regRd && regAddr == urf_pkg::LINE_FLAGS_OFS;
  assign bitLen = {16'h0, div_q} * (fast_q ? 32'h8 : 32'h10);
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rlc_q <= 8'h00;
      div_q <= 16'h0000;
      fast_q <= 1'b0;
    end
    else if (regWr)
    begin
      if (regAddr == urf_pkg::RX_LINE_CONTROL_OFS)
        rlc_q <= regWdata[7:0] & urf_pkg::RLC_MASK;
      if (regAddr == urf_pkg::BAUD_INTEGER_OFS)
        div_q <= regWdata[15:0];
      if (regAddr == urf_pkg::CONTROL_OFS)
        fast_q <= regWdata[urf_pkg::CTL_OVERSAMPLE];
    end
  end
  // a cts change marks a pending delta; a flag read with no change clears it
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctsPrev_q <= 1'b0;
      chg_q <= 1'b1;
      lowRun_q <= 32'h0;
    end
    else
    begin
      ctsPrev_q <= clearToSend;
      lowRun_q <= txLine ? 32'h0 : lowRun_q + 32'h1;
      if (clearToSend != ctsPrev_q)
        chg_q <= 1'b1;
      else if (flagsRd)
        chg_q <= 1'b0;
    end
  end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  property p_flag_rsv;
    flagsRd |=> regRdata[12:10] == urf_pkg::FLAG_RSV_VALUE && regRdata[31:14] == 18'h0
      && regRdata[8] == 1'b0 && regRdata[2:1] == 2'h0;
  endproperty
  a_flag_rsv: assert property (p_flag_rsv)
    else $error("flag reserved bits wrong");
  property p_rlc_store;
    regRd && regAddr == urf_pkg::RX_LINE_CONTROL_OFS |=> regRdata == {24'h0, rlc_q};
  endproperty
  a_rlc_store: assert property (p_rlc_store)
    else $error("line control readback wrong");
  property p_int_store;
    regRd && regAddr == urf_pkg::BAUD_INTEGER_OFS |=> regRdata == {16'h0, div_q};
  endproperty
  a_int_store: assert property (p_int_store)
    else $error("divisor readback wrong");
  property p_frac_width;
    regRd && regAddr == urf_pkg::BAUD_FRACTION_OFS |=> regRdata[31:6] == 26'h0;
  endproperty
  a_frac_width: assert property (p_frac_width)
    else $error("fraction too wide");
  property p_cts_set;
    flagsRd && chg_q |=> regRdata[urf_pkg::FLAG_CTS_DELTA];
  endproperty
  a_cts_set: assert property (p_cts_set)
    else $error("cts delta missing");
  property p_cts_clear;
    flagsRd && !chg_q |=> !regRdata[urf_pkg::FLAG_CTS_DELTA];
  endproperty
  a_cts_clear: assert property (p_cts_clear)
    else $error("cts delta not cleared");
  property p_busy;
    regWr && regAddr == urf_pkg::TX_DATA_OFS ##2 flagsRd |=> regRdata[urf_pkg::FLAG_BUSY];
  endproperty
  a_busy: assert property (p_busy)
    else $error("busy low with data queued");
  property p_tx_bitlen;
    $rose(txLine) |-> lowRun_q >= bitLen;
  endproperty
  a_tx_bitlen: assert property (p_tx_bitlen)
    else $error("start bit too short");
  c_cts: cover property (flagsRd && !chg_q);
  c_tx: cover property ($fell(txLine));
  c_irq: cover property ($rose(irq));
endmodule : urf_uart_sva

/* sim/urf_remote_peer.sv */
/*
  remote serial transceiver: drives receive frames, collects sent bytes.
  assumes bitLen is set by the bench to the device's bit time.
*/
module urf_remote_peer (
  input wire logic clk,
  input wire logic txLine,
  output logic rxLine,
  output logic clearToSend
);
  timeunit 1ns;
  timeprecision 1ns;
  int bitLen = 8;
  logic [7:0] got[$];
  logic [7:0] sh;
  initial
  begin
    rxLine = 1'b1;
    clearToSend = 1'b0;
  end
  task automatic bit_out(input logic b);
    rxLine <= b;
    repeat (bitLen) @(posedge clk);
  endtask : bit_out
  task automatic send(input logic [7:0] d, input int nb, input logic hasPar,
                      input logic parBit, input logic twoStop, input logic lastStop);
    bit_out(1'b0);
    for (int i = 0; i < nb; i++)
      bit_out(d[i]);
    if (hasPar)
      bit_out(parBit);
    bit_out(1'b1);
    if (twoStop)
      bit_out(lastStop);
    rxLine <= 1'b1;
    @(posedge clk);
  endtask : send
  // mid-bit sampling; the device always sends eight data bits
  always
  begin
    @(negedge txLine);
    repeat (bitLen / 2) @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (bitLen) @(posedge clk);
      sh[i] = txLine;
    end
    repeat (bitLen) @(posedge clk);
    got.push_back(sh);
  end
endmodule : urf_remote_peer

/* sim/uart_rx_format_flags_baud_bench.sv */
/*
  self-checking bench for the serial port block with a remote peer.
  assumes checker and peer files are compiled first; bind at the foot.
*/
module uart_rx_format_flags_baud_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] FL = urf_pkg::LINE_FLAGS_OFS;
  localparam logic [7:0] RLC = urf_pkg::RX_LINE_CONTROL_OFS;
  localparam logic [7:0] BI = urf_pkg::BAUD_INTEGER_OFS;
  localparam logic [7:0] BF = urf_pkg::BAUD_FRACTION_OFS;
  localparam logic [7:0] CT = urf_pkg::CONTROL_OFS;
  localparam logic [7:0] TXD = urf_pkg::TX_DATA_OFS;
  localparam logic [7:0] RXD = urf_pkg::RX_DATA_OFS;
  localparam logic [7:0] IST = urf_pkg::IRQ_STATUS_OFS;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] regRdata;
  logic rxLine;
  logic clearToSend;
  logic txLine;
  logic irq;
  int errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  always #25 clk = ~clk;
  urf_uart #(.Depth(16)) i_dut (
    .clk(clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .rxLine(rxLine), .clearToSend(clearToSend),
    .txLine(txLine), .irq(irq)
  );
  urf_remote_peer i_peer (
    .clk(clk), .txLine(txLine), .rxLine(rxLine), .clearToSend(clearToSend)
  );
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(posedge clk);
    chk(regRdata & m, e);
  endtask : rchk
  // stick parity sends the inverse of the even select
  function automatic logic par_of(input logic [7:0] d, input logic sk, input logic ev);
    return sk ? !ev : (ev ? ^d : ~^d);
  endfunction : par_of
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      errors++;
      report_and_stop();
    end
  end
  initial
  begin
    logic [7:0] d;
    logic [31:0] w;
    logic pe;
    logic ev;
    logic sk;
    logic s2;
    logic bad;
    logic bs;
    logic [7:0] dl;
    void'($urandom(32'h5ad2));
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    rchk(FL, 32'hffffffff, 32'h1e90);
    rchk(FL, 32'h200, 32'h0);
    rchk(RLC, 32'hffffffff, 32'h0);
    rchk(BI, 32'hffffffff, 32'h0);
    rchk(BF, 32'hffffffff, 32'h0);
    rchk(8'h0c, 32'hffffffff, 32'h0);
    repeat (4)
    begin
      w = $urandom;
      wr(RLC, w);
      rchk(RLC, 32'hffffffff, {24'h0, w[7:0] & urf_pkg::RLC_MASK});
      wr(BI, w);
      rchk(BI, 32'hffffffff, {16'h0, w[15:0]});
      wr(BF, w);
      rchk(BF, 32'hffffffff, {26'h0, w[5:0]});
    end
    wr(BF, 32'h0);
    wr(BI, 32'h1);
    i_peer.clearToSend <= 1'b1;
    repeat (6) @(posedge clk);
    rchk(FL, 32'h201, 32'h201);
    repeat (6) @(posedge clk);
    rchk(FL, 32'h201, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr(IST, 32'hf);
    wr(urf_pkg::IRQ_MASK_OFS, 32'h1);
    for (int k = 0; k < 2; k++)
    begin
      wr(CT, k ? 32'h0 : 32'h2);
      i_peer.bitLen = k ? 16 : 8;
      i_peer.got.delete();
      d = 8'($urandom);
      wr(TXD, {24'h0, d});
      rchk(FL, 32'h8, 32'h8);
      repeat (12 * i_peer.bitLen) @(posedge clk);
      chk({24'h0, i_peer.got[0]}, {24'h0, d});
      rchk(FL, 32'h88, 32'h80);
    end
    // slow divisor so the holding place and the queue fill before draining
    wr(BI, 32'ha);
    i_peer.bitLen = 80;
    for (int k = 0; k < 2; k++)
    begin
      wr(CT, k ? 32'h3 : 32'h2);
      repeat (k ? 17 : 2) wr(TXD, $urandom);
      rchk(FL, 32'ha0, 32'h20);
      repeat ((k ? 18 : 3) * 800) @(posedge clk);
      rchk(FL, 32'h88, 32'h80);
    end
    wr(BI, 32'h1);
    wr(CT, 32'h2);
    i_peer.bitLen = 8;
    for (int i = 0; i < 16; i++)
    begin
      pe = (i / 4) != 0;
      ev = (i / 4) == 1 || ((i / 4) == 3 && i[0]);
      sk = (i / 4) == 3;
      s2 = i[1];
      bad = pe && (i % 3 == 0);
      bs = s2 && i[0];
      d = 8'($urandom) & (8'hff >> (3 - i % 4));
      wr(RLC, {24'h0, sk, 2'(i % 4), 1'b0, s2, ev, pe, 1'b0});
      i_peer.send(d, 5 + i % 4, pe, par_of(d, sk, ev) ^ bad, s2, !bs);
      repeat (16) @(posedge clk);
      // a bad second stop drops the character; the holding place keeps the last one
      rchk(FL, 32'h50, bs ? 32'h10 : 32'h40);
      chk({31'h0, irq}, {31'h0, !bs});
      dl = bs ? dl : d;
      rchk(RXD, 32'hff, {24'h0, dl});
      rchk(IST, 32'h7, {29'h0, bs, bad && !bs, !bs});
      wr(IST, 32'hf);
      @(posedge clk);
      chk({31'h0, irq}, 32'h0);
    end
    wr(urf_pkg::FLOW_CONTROL_OFS, 32'h00131101);
    wr(CT, 32'h6);
    wr(RLC, 32'h70);
    i_peer.got.delete();
    for (int k = 0; k < 3; k++)
      i_peer.send(8'h30 + 8'(k), 8, 1'b0, 1'b0, 1'b0, 1'b1);
    repeat (120) @(posedge clk);
    chk({24'h0, i_peer.got[0]}, {24'h0, urf_pkg::XOFF_RESET});
    rchk(FL, 32'h2050, 32'h2000);
    for (int k = 0; k < 3; k++)
      rchk(RXD, 32'hff, 32'h30 + k);
    repeat (120) @(posedge clk);
    chk({24'h0, i_peer.got[1]}, {24'h0, urf_pkg::XON_RESET});
    rchk(FL, 32'h2000, 32'h0);
    report_and_stop();
  end
endmodule : uart_rx_format_flags_baud_bench

bind urf_uart urf_uart_sva i_sva (
  .clk(clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
  .regRd(regRd), .regRdata(regRdata), .rxLine(rxLine), .clearToSend(clearToSend),
  .txLine(txLine), .irq(irq)
);
